// ===== design/pot_link_pkg.sv
// Constants, rule overview and state encodings for the two-wire instruction block.
// Overview of operation
// - Both auxiliary outputs low after power-up.
// - Auxiliary outputs follow instruction byte bit positions.
// - Instruction without data byte leaves wipers alone unless its midscale bit sets the selected wiper to midscale.
// - Address, instruction, STOP updates outputs without data.
// - New transfer after STOP may carry instruction only.
// - Repeated START abandons write, new instruction accepted.
// - Shutdown by low pin or instruction bit.
// - Answer only the strap-selected slave address.
// - Address is fixed prefix, two straps, direction.
// - Instruction byte field order, MSB first.
// - Bit shuts selected channel, pin all; wipers kept.
package pot_link_pkg;
	localparam logic [4:0] ADDR_PREFIX = 5'h0B;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
	localparam logic AUX_RESET = 1'b0;
	localparam logic [3:0] OFF_RESET = 4'h0;
	// Instruction byte bit positions.
	localparam int SEL_HI_POS = 6;
	localparam int SEL_LO_POS = 5;
	localparam int MIDSCALE_POS = 4;
	localparam int CHAN_OFF_POS = 3;
	localparam int AUX_TWO_POS = 2;
	localparam int AUX_ONE_POS = 1;
	// Synchroniser vector positions.
	localparam int PIN_SCL = 2;
	localparam int PIN_SDA = 1;
	localparam int PIN_PDN = 0;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_INSTR = 9'h008,
		ST_IACK = 9'h010,
		ST_DATA = 9'h020,
		ST_DACK = 9'h040,
		ST_TX = 9'h080,
		ST_RACK = 9'h100
	} link_state_t;
endpackage

// ===== design/pot_link_slave.sv
// Two-wire slave: instruction decode, auxiliary outputs, shutdown and wiper registers.
`timescale 1ns/1ps
module pot_link_slave import pot_link_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Two-wire bus, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Device pins
	input wire logic addr_strap_low,
	input wire logic addr_strap_high,
	input wire logic global_powerdown_pin_n,
	output logic aux_out_one,
	output logic aux_out_two,
	// Channel state toward the resistor arrays
	output logic [3:0] chan_shutdown,
	output logic [31:0] wiper_register
);
	typedef struct packed {
		logic [2:0] pin1;
		logic [2:0] pin2;
		logic [1:0] strap1;
		logic [1:0] strap2;
		logic scl_p;
		logic sda_p;
		link_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic [1:0] sel;
		logic ack;
		logic oe;
		logic aux1;
		logic aux2;
		logic [3:0] off;
		logic [3:0] shut;
		logic [3:0][7:0] wiper;
	} core_state_t;

	core_state_t s_r;
	core_state_t s_nxt;
	logic scl;
	logic sda;
	logic pdn;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic instr_take;
	logic [6:0] dev_addr;

	assign scl = s_r.pin2[PIN_SCL];
	assign sda = s_r.pin2[PIN_SDA];
	assign pdn = s_r.pin2[PIN_PDN];
	assign rise = scl & ~s_r.scl_p;
	assign fall = ~scl & s_r.scl_p;
	assign start = scl & s_r.scl_p & s_r.sda_p & ~sda;
	assign stop = scl & s_r.scl_p & ~s_r.sda_p & sda;
	assign dev_addr = {ADDR_PREFIX, s_r.strap2[1], s_r.strap2[0]};

	always_comb begin
		s_nxt = s_r;
		instr_take = 1'b0;
		s_nxt.pin1 = {scl_in, sda_in, global_powerdown_pin_n};
		s_nxt.pin2 = s_r.pin1;
		s_nxt.strap1 = {addr_strap_high, addr_strap_low};
		s_nxt.strap2 = s_r.strap1;
		s_nxt.scl_p = scl;
		s_nxt.sda_p = sda;
		// Pin shuts every channel; bits only their own, wipers untouched.
		s_nxt.shut = s_r.off | {4{~pdn}};
		if (start) begin
			// A START in any state, even mid-write, begins a fresh address.
			s_nxt.st = ST_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.oe = 1'b0;
		end else if (stop) begin
			s_nxt.st = ST_IDLE;
			s_nxt.oe = 1'b0;
		end else begin
			case (s_r.st)
				ST_ADDR, ST_INSTR, ST_DATA: begin
					if (rise && s_r.cnt < BITS_PER_BYTE) begin
						s_nxt.sh = {s_r.sh[6:0], sda};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (fall && s_r.cnt == BITS_PER_BYTE) begin
						s_nxt.cnt = 4'h0;
						s_nxt.oe = 1'b1;
						if (s_r.st == ST_ADDR) begin
							if (s_r.sh[7:1] != dev_addr) begin
								s_nxt.st = ST_IDLE;
								s_nxt.oe = 1'b0;
							end else begin
								s_nxt.st = ST_AACK;
								s_nxt.rw = s_r.sh[0];
							end
						end else if (s_r.st == ST_INSTR) begin
							// Applied at the instruction ack, so no data byte is needed.
							instr_take = 1'b1;
							s_nxt.st = ST_IACK;
							s_nxt.aux1 = s_r.sh[AUX_ONE_POS];
							s_nxt.aux2 = s_r.sh[AUX_TWO_POS];
							s_nxt.sel = {s_r.sh[SEL_HI_POS], s_r.sh[SEL_LO_POS]};
							s_nxt.off[{s_r.sh[SEL_HI_POS], s_r.sh[SEL_LO_POS]}] =
								s_r.sh[CHAN_OFF_POS];
							if (s_r.sh[MIDSCALE_POS]) begin
								s_nxt.wiper[{s_r.sh[SEL_HI_POS], s_r.sh[SEL_LO_POS]}] =
									WIPER_MIDSCALE;
							end
						end else begin
							s_nxt.st = ST_DACK;
							s_nxt.wiper[s_r.sel] = s_r.sh;
						end
					end
				end
				ST_AACK: begin
					if (fall) begin
						s_nxt.oe = 1'b0;
						s_nxt.st = ST_INSTR;
						if (s_r.rw) begin
							s_nxt.st = ST_TX;
							s_nxt.sh = s_r.wiper[s_r.sel];
							s_nxt.oe = ~s_r.wiper[s_r.sel][7];
						end
					end
				end
				ST_IACK, ST_DACK: begin
					// Further data bytes keep rewriting the selected wiper.
					if (fall) begin
						s_nxt.oe = 1'b0;
						s_nxt.st = ST_DATA;
					end
				end
				ST_TX: begin
					if (rise) begin
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (fall) begin
						if (s_r.cnt == BITS_PER_BYTE) begin
							s_nxt.oe = 1'b0;
							s_nxt.st = ST_RACK;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.oe = ~s_r.sh[6];
						end
					end
				end
				ST_RACK: begin
					if (rise) begin
						s_nxt.ack = ~sda;
					end else if (fall) begin
						s_nxt.st = ST_IDLE;
						if (s_r.ack) begin
							s_nxt.st = ST_TX;
							s_nxt.cnt = 4'h0;
							s_nxt.sh = s_r.wiper[s_r.sel];
							s_nxt.oe = ~s_r.wiper[s_r.sel][7];
						end
					end
				end
				default: begin
					s_nxt.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.pin1 <= 3'h7;
			s_r.pin2 <= 3'h7;
			s_r.scl_p <= 1'b1;
			s_r.sda_p <= 1'b1;
			s_r.st <= ST_IDLE;
			s_r.aux1 <= AUX_RESET;
			s_r.aux2 <= AUX_RESET;
			s_r.off <= OFF_RESET;
			s_r.wiper <= {4{WIPER_MIDSCALE}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// The line is only ever pulled low; the pad data stays zero.
	assign sda_out = 1'b0;
	assign sda_oe = s_r.oe;
	assign aux_out_one = s_r.aux1;
	assign aux_out_two = s_r.aux2;
	assign chan_shutdown = s_r.shut;
	assign wiper_register = s_r.wiper;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_start_seen;
		scl && s_r.scl_p && s_r.sda_p && !sda;
	endsequence
	sequence s_addr_done;
		s_r.st == ST_ADDR && fall && s_r.cnt == BITS_PER_BYTE;
	endsequence

	property p_aux_reset;
		$past(rst) |-> !aux_out_one && !aux_out_two;
	endproperty
	a_aux_reset: assert property (p_aux_reset) else $error("aux not low after reset");
	property p_aux_bits;
		instr_take |=> aux_out_one == $past(s_r.sh[1]) && aux_out_two == $past(s_r.sh[2]);
	endproperty
	a_aux_bits: assert property (p_aux_bits) else $error("aux not from instr");
	property p_no_wiper_touch;
		instr_take && !s_r.sh[MIDSCALE_POS] |=> $stable(wiper_register);
	endproperty
	a_no_wiper_touch: assert property (p_no_wiper_touch) else $error("wiper moved");
	property p_aux_hold;
		!instr_take |=> $stable(aux_out_one) && $stable(aux_out_two);
	endproperty
	a_aux_hold: assert property (p_aux_hold) else $error("aux changed unasked");
	property p_pin_off;
		!pdn |=> chan_shutdown == 4'hF;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin shutdown missed");
	property p_bit_off;
		instr_take |=> ##1 chan_shutdown[$past(s_r.sh[6:5], 2)] == ($past(s_r.sh[3], 2) | ~$past(pdn));
	endproperty
	a_bit_off: assert property (p_bit_off) else $error("channel off bit wrong");
	property p_addr_nak;
		s_addr_done and (s_r.sh[7:1] != dev_addr) |=> !sda_oe && s_r.st == ST_IDLE;
	endproperty
	a_addr_nak: assert property (p_addr_nak) else $error("acked foreign address");
	property p_addr_ack;
		s_addr_done and (s_r.sh[7:1] == dev_addr) |=> sda_oe ##1 s_r.st == ST_AACK;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
	property p_restart;
		s_start_seen |=> s_r.st == ST_ADDR && s_r.cnt == 4'h0 && !sda_oe;
	endproperty
	a_restart: assert property (p_restart) else $error("START not taken");
	property p_midscale;
		instr_take && s_r.sh[MIDSCALE_POS] |=> s_r.wiper[$past(s_r.sh[6:5])] == WIPER_MIDSCALE;
	endproperty
	a_midscale: assert property (p_midscale) else $error("midscale not applied");
endmodule // pot_link_slave

// ===== dv/i2c_master_model.sv
// Two-wire bus master model that drives the clock line and pulls the data line.
`timescale 1ns/1ps
module i2c_master_model (
	// Clock
	input wire logic ref_clk,
	// Bus
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Each bus phase lasts five cycles, above the three that the slave needs.
	task automatic half();
		repeat (5) @(posedge ref_clk);
		#1;
	endtask
	// Also serves as a repeated START that abandons a write.
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
	endtask
	task automatic put_bit(input logic b, output logic got);
		sda_low = ~b;
		half();
		scl = 1'b1;
		half();
		got = sda;
		scl = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], g);
		end
		put_bit(1'b1, g);
		ack = ~g;
	endtask
	// Reads one byte with the line released, then acks it when more bytes are wanted.
	task automatic get_byte(input logic mack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, g);
			d[i] = g;
		end
		put_bit(~mack, g);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask
endmodule // i2c_master_model

// ===== dv/test_pot_link_slave.sv
// Self-checking bench for the two-wire instruction slave.
`timescale 1ns/1ps
module test_pot_link_slave;
	import pot_link_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic strap_l = 1'b0;
	logic strap_h = 1'b0;
	logic pdn_n = 1'b1;
	logic scl, m_low, sda_out, sda_oe, aux1, aux2, ack, ok;
	logic [3:0] off_v, off_e;
	logic [31:0] wip_v, wip_e, seed;
	logic [1:0] aux_e;
	logic [54:0] exp_v;
	logic [54:0] notes[$];
	logic [15:0] rdat = 16'h0000;
	logic [15:0] rdat_e = 16'h0000;
	logic [1:0] sel_e = 2'h0;
	int error_cnt = 0;
	int checks_done = 0;
	event done_ev;
	// Data line has a pull-up, so a released line reads high.
	wire logic sda = ~m_low & (sda_oe ? sda_out : 1'b1);
	always #5 ref_clk = ~ref_clk;
	pot_link_slave pot_link_slave_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(strap_l), .addr_strap_high(strap_h),
		.global_powerdown_pin_n(pdn_n), .aux_out_one(aux1), .aux_out_two(aux2),
		.chan_shutdown(off_v), .wiper_register(wip_v));
	i2c_master_model i2c_master_model_i (.ref_clk(ref_clk), .scl(scl), .sda_low(m_low), .sda(sda));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic note(input logic ack_e);
		notes.push_back({rdat_e, ack_e, aux_e, off_e | {4{~pdn_n}}, wip_e});
		repeat (8) @(posedge ref_clk);
		// Compared mid-cycle, away from the edge that updates the outputs.
		@(negedge ref_clk);
		->done_ev;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] ins, input logic nd,
		input logic [7:0] d, input logic stp);
		i2c_master_model_i.start();
		i2c_master_model_i.put_byte(adr, ack);
		ok = (adr == {ADDR_PREFIX, strap_h, strap_l, 1'b0});
		if (ok) begin
			i2c_master_model_i.put_byte(ins, ack);
			aux_e = {ins[AUX_TWO_POS], ins[AUX_ONE_POS]};
			sel_e = ins[6:5];
			off_e[ins[6:5]] = ins[CHAN_OFF_POS];
			if (ins[MIDSCALE_POS])
				wip_e[8 * ins[6:5] +: 8] = WIPER_MIDSCALE;
			if (nd) begin
				i2c_master_model_i.put_byte(d, ack);
				wip_e[8 * ins[6:5] +: 8] = d;
			end
		end
		if (stp)
			i2c_master_model_i.stop();
		note(ok);
	endtask
	// Reads the last selected wiper twice: first byte acked, second not.
	task automatic rd(input logic [7:0] adr);
		rdat_e = {2{wip_e[8 * sel_e +: 8]}};
		i2c_master_model_i.start();
		i2c_master_model_i.put_byte(adr | 8'h01, ack);
		i2c_master_model_i.get_byte(1'b1, rdat[15:8]);
		i2c_master_model_i.get_byte(1'b0, rdat[7:0]);
		i2c_master_model_i.stop();
		note(1'b1);
	endtask
	always @(done_ev) begin
		exp_v = notes.pop_front();
		checks_done++;
		if (exp_v !== {rdat, ack, aux2, aux1, off_v, wip_v}) begin
			error_cnt++;
			$display("ERROR rd_ack_aux_off_wipers expected %h seen %h", exp_v,
				{rdat, ack, aux2, aux1, off_v, wip_v});
		end
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic [7:0] a;
		logic [31:0] r;
		seed = 32'h688BCC7B;
		r = rnd();
		{strap_h, strap_l} = r[1:0];
		aux_e = 2'h0;
		off_e = OFF_RESET;
		wip_e = {4{WIPER_MIDSCALE}};
		ack = 1'b0;
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge ref_clk);
		note(1'b0);
		$display("test reset done");
		a = {ADDR_PREFIX, strap_h, strap_l, 1'b0};
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			wr(a, r[7:0], r[8], r[31:24], 1'b1);
		end
		rd(a);
		$display("test instruction updates done");
		wr(a, 8'h26, 1'b1, 8'h5A, 1'b0);
		wr(a, 8'h42, 1'b0, 8'h00, 1'b1);
		$display("test repeated start done");
		for (int s = 1; s < 4; s++) begin
			wr(a ^ {5'h00, s[1:0], 1'b0}, 8'h06, 1'b0, 8'h00, 1'b1);
		end
		$display("test foreign address done");
		pdn_n = 1'b0;
		wr(a, 8'h08, 1'b1, 8'h3C, 1'b1);
		pdn_n = 1'b1;
		note(1'b1);
		$display("test shutdown done");
		rd(a);
		$display("test readback done");
		print_verdict();
	end
endmodule // test_pot_link_slave
